// ===== afs_defs.svh
// Constants for the acquisition front-end select decoder.
// Assumes inclusion by bare name from any file that decodes the front-end fields.
`ifndef AFS_DEFS_SVH
`define AFS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define AFS_ADDR_INSEL     8'h00
`define AFS_ADDR_ENABLE    8'h04
`define AFS_ADDR_STAGE2    8'h08
`define AFS_ADDR_STAGE3G   8'h0c
`define AFS_ADDR_STAGE3O   8'h10
`define AFS_ADDR_SWITCH    8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AFS_REF_BIT        0
`define AFS_MUX_LSB        1
`define AFS_MUX_MSB        5
`define AFS_MUX_MODE       4
`define AFS_MUX_SIGN       3
`define AFS_EN_MOD         0
`define AFS_S1_GAIN_BIT    7
`define AFS_S2_OFF_LSB     0
`define AFS_S2_OFF_MSB     3
`define AFS_S2_GAIN_LSB    4
`define AFS_S2_GAIN_MSB    5
`define AFS_S2_OFF_SIGN    3
`define AFS_S3_OFF_SIGN    6

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define AFS_RST_INSEL      8'h00
`define AFS_RST_ENABLE     4'h1
`define AFS_RST_STAGE2     6'h00
`define AFS_RST_STAGE3     8'h00
`define AFS_S2_MAG_MAX     3'h5
`define AFS_PAIR_NEG       3'h0
`define AFS_COMMON_REF     3'h0

`endif

// ===== afs_pkg.sv
// Types for the acquisition front-end select decoder.
// Assumes afs_defs.svh is available on the include path.
`default_nettype none

package afs_pkg;

    // Input selector configuration.
    typedef enum logic
    {
        AFS_MODE_DIFF,
        AFS_MODE_COMMON
    } afs_mux_mode_t;

    // Stage-two gain selection.
    typedef enum logic [1:0]
    {
        AFS_G2_X1,
        AFS_G2_X2,
        AFS_G2_X5,
        AFS_G2_X10
    } afs_gain2_t;

endpackage

`default_nettype wire

// ===== afs_decoder.sv
// Acquisition front-end select decoder: registers plus switch decode.
// Assumes a classic Wishbone master on sys_clk and analog switch arrays
// that take one-hot selects held from flip-flops.
//
// Behaviour
// - Mux mode bit chooses four differential pairs or seven inputs over input 0.
// - Differential, sign clear: pair k, positive input 2k+1, negative input 2k.
// - Differential, sign set: positive and negative of the pair are swapped.
// - Common mode: input n positive, input 0 negative; sign set exchanges them.
// - Reference select 0 picks references 1/0, select 1 picks references 3/2.
// - Enable bits drive modulator and three stages; disabled stages are bypassed.
// - Stage-one gain bit gives unity when 0 and ten when 1.
// - Stage-two gain codes 00,01,10,11 give gains 1,2,5,10.
// - Stage-two offset is sign-magnitude, magnitude 0..5 in steps of 0.2.
// - Stage-three gain code n selects gain n/12.
// - Stage-three offset is sign-magnitude m/12; negative zero is zero.
// - Path runs selector, stage one, two, three, then modulator.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "afs_defs.svh"

module afs_decoder
    import afs_pkg::*;
#(
    parameter int NUM_INPUTS = 8,
    parameter int NUM_REFS   = 4
)
(
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // Wishbone slave.
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // Input selector switches, one-hot.
    output logic [NUM_INPUTS-1:0]      inp_pos_sel,
    output logic [NUM_INPUTS-1:0]      inp_neg_sel,
    // Reference selector switches, one-hot.
    output logic [NUM_REFS-1:0]        ref_pos_sel,
    output logic [NUM_REFS-1:0]        ref_neg_sel,
    // Stage activation and bypass.
    output logic                       modulator_en,
    output logic [2:0]                 stage_en,
    output logic [2:0]                 stage_bypass,
    // Stage-one gain: 0 unity, 1 ten.
    output logic                       stage1_gain_ten,
    // Stage-two gain one-hot {x10,x5,x2,x1}.
    output logic [3:0]                 stage2_gain_oh,
    // Stage-two offset capacitor select: thermometer magnitude and sign.
    output logic [4:0]                 stage2_offset_therm,
    output logic                       stage2_offset_neg,
    // Stage-three gain and offset capacitor words.
    output logic [6:0]                 stage3_gain_word,
    output logic [5:0]                 stage3_offset_mag,
    output logic                       stage3_offset_neg
);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] input_select_config_q;   // Bit 0 reference, bits 5:1 selector.
    logic [3:0] enable_q;
    logic [5:0] stage2_q;                // Gain in 5:4, offset in 3:0.
    logic [7:0] stage3_gain_q;           // Stage-one gain in 7, stage-three gain 6:0.
    logic [6:0] stage3_offset_q;
    logic       ack_q;
    logic       err_q;
    logic [31:0] rdata_q;

    logic        req;
    logic        wr;
    logic        hit;
    logic [31:0] rdata_d;

    // A request is taken once; a write lands at the edge at which the master
    // samples ack high, while address, data and byte lanes still stand.
    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign wr  = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && hit;

    // Address decode and read data mux; the switch status word mirrors the
    // decoded outputs so software can see what the arrays are given.
    always_comb
    begin
        hit     = 1'b1;
        rdata_d = 32'h0;
        case (wb_adr_i)
            `AFS_ADDR_INSEL:   rdata_d[7:0] = {2'h0, input_select_config_q[5:0]};
            `AFS_ADDR_ENABLE:  rdata_d[3:0] = enable_q;
            `AFS_ADDR_STAGE2:  rdata_d[5:0] = stage2_q;
            `AFS_ADDR_STAGE3G: rdata_d[7:0] = stage3_gain_q;
            `AFS_ADDR_STAGE3O: rdata_d[6:0] = stage3_offset_q;
            `AFS_ADDR_SWITCH:  rdata_d[23:0] = {ref_pos_sel, ref_neg_sel, inp_pos_sel, inp_neg_sel};
            default:           hit = 1'b0;
        endcase
    end

    // Bus handshake: one wait-free answer the cycle after the request.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            ack_q   <= req && hit;
            err_q   <= req && !hit;
            rdata_q <= (req && hit && !wb_we_i) ? rdata_d : 32'h0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata_q;

    // Register writes, byte lane 0 only; upper bits are ignored.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            input_select_config_q <= `AFS_RST_INSEL;
            enable_q              <= `AFS_RST_ENABLE;
            stage2_q              <= `AFS_RST_STAGE2;
            stage3_gain_q         <= `AFS_RST_STAGE3;
            stage3_offset_q       <= 7'h00;
        end
        else if (wr && wb_sel_i[0])
        begin
            case (wb_adr_i)
                `AFS_ADDR_INSEL:   input_select_config_q <= {2'h0, wb_dat_i[5:0]};
                `AFS_ADDR_ENABLE:  enable_q <= wb_dat_i[3:0];
                `AFS_ADDR_STAGE2:  stage2_q <= wb_dat_i[5:0];
                `AFS_ADDR_STAGE3G: stage3_gain_q <= wb_dat_i[7:0];
                `AFS_ADDR_STAGE3O: stage3_offset_q <= wb_dat_i[6:0];
                default:           ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Input and reference selector decode
    // ----------------------------------------------------------------
    logic [4:0]    mux;
    afs_mux_mode_t mode;
    logic          sign;
    logic [2:0]    pos_idx;
    logic [2:0]    neg_idx;

    assign mux  = input_select_config_q[`AFS_MUX_MSB:`AFS_MUX_LSB];
    assign mode = afs_mux_mode_t'(mux[`AFS_MUX_MODE]);
    assign sign = mux[`AFS_MUX_SIGN];

    // Pick the positive and negative input indices for the selected mode.
    always_comb
    begin
        case (mode)
            AFS_MODE_DIFF:
            begin
                pos_idx = {mux[1:0], 1'b1};
                neg_idx = {mux[1:0], 1'b0};
                if (sign)
                begin
                    pos_idx = {mux[1:0], 1'b0};
                    neg_idx = {mux[1:0], 1'b1};
                end
            end
            default:
            begin
                pos_idx = sign ? `AFS_COMMON_REF : mux[2:0];
                neg_idx = sign ? mux[2:0] : `AFS_COMMON_REF;
            end
        endcase
    end

    // Register the one-hot switch selects so the arrays see clean levels.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            inp_pos_sel <= '0;
            inp_neg_sel <= '0;
            ref_pos_sel <= '0;
            ref_neg_sel <= '0;
        end
        else
        begin
            inp_pos_sel <= NUM_INPUTS'(1) << pos_idx;
            inp_neg_sel <= NUM_INPUTS'(1) << neg_idx;
            ref_pos_sel <= input_select_config_q[`AFS_REF_BIT] ? NUM_REFS'(8) : NUM_REFS'(2);
            ref_neg_sel <= input_select_config_q[`AFS_REF_BIT] ? NUM_REFS'(4) : NUM_REFS'(1);
        end
    end

    // ----------------------------------------------------------------
    // Stage enables and capacitor ratio decode
    // ----------------------------------------------------------------
    logic [2:0] s2_mag;
    logic       s2_valid;
    logic [4:0] s2_therm;

    assign s2_mag   = stage2_q[2:0];
    assign s2_valid = (s2_mag != 3'h0) && (s2_mag <= `AFS_S2_MAG_MAX);

    // Thermometer code: one 0.2 capacitor per magnitude step.
    always_comb
    begin
        s2_therm = 5'h00;
        for (int i = 0; i < 5; i++)
        begin
            if (s2_valid && (3'(i) < s2_mag))
            begin
                s2_therm[i] = 1'b1;
            end
        end
    end

    // Stage enables, bypass switches in series order, gains and offsets.
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            modulator_en        <= 1'b0;
            stage_en            <= 3'h0;
            stage_bypass        <= 3'h7;
            stage1_gain_ten     <= 1'b0;
            stage2_gain_oh      <= 4'h1;
            stage2_offset_therm <= 5'h00;
            stage2_offset_neg   <= 1'b0;
            stage3_gain_word    <= 7'h00;
            stage3_offset_mag   <= 6'h00;
            stage3_offset_neg   <= 1'b0;
        end
        else
        begin
            modulator_en        <= enable_q[`AFS_EN_MOD];
            stage_en            <= enable_q[3:1];
            stage_bypass        <= ~enable_q[3:1];
            stage1_gain_ten     <= stage3_gain_q[`AFS_S1_GAIN_BIT];
            stage2_gain_oh      <= 4'h1 << stage2_q[`AFS_S2_GAIN_MSB:`AFS_S2_GAIN_LSB];
            stage2_offset_therm <= s2_therm;
            stage2_offset_neg   <= s2_valid && stage2_q[`AFS_S2_OFF_SIGN];
            stage3_gain_word    <= stage3_gain_q[6:0];
            stage3_offset_mag   <= stage3_offset_q[5:0];
            stage3_offset_neg   <= stage3_offset_q[`AFS_S3_OFF_SIGN] && (stage3_offset_q[5:0] != 6'h00);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    diff_pair_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr && wb_adr_i == `AFS_ADDR_INSEL && wb_sel_i[0] && wb_dat_i[5:4] == 2'b00)
        |=> ##1 (inp_pos_sel == (NUM_INPUTS'(2) << ({1'b0, $past(wb_dat_i[2:1], 2)} * 2))))
        else $error("differential pair positive select wrong");

    diff_swap_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode == AFS_MODE_DIFF && sign) |=> (inp_pos_sel == (NUM_INPUTS'(1) << {$past(mux[1:0]), 1'b0})))
        else $error("swapped pair positive select wrong");

    common_ref_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (mode == AFS_MODE_COMMON && !sign) |=> inp_neg_sel == NUM_INPUTS'(1))
        else $error("common reference not on negative side");

    ref_sel_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(input_select_config_q[0]) |=> (ref_pos_sel == NUM_REFS'(8) && ref_neg_sel == NUM_REFS'(4)))
        else $error("reference select wrong");

    bypass_path_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 (stage_bypass == ~stage_en))
        else $error("stage bypass not complement of enable");

    stage2_gain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $onehot(stage2_gain_oh))
        else $error("stage two gain not one-hot");

    s2_invalid_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (stage2_q[2:0] > 3'h5) |=> (stage2_offset_therm == 5'h00 && !stage2_offset_neg))
        else $error("undefined stage two offset not zeroed");

    s3_negzero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (stage3_offset_q == 7'h40) |=> !stage3_offset_neg)
        else $error("negative zero offset marked negative");

    mod_enable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr && wb_adr_i == `AFS_ADDR_ENABLE && wb_sel_i[0]) |=> ##1 (modulator_en == $past(wb_dat_i[0], 2)))
        else $error("modulator enable not following write");

    stage_gain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 ({stage1_gain_ten, stage3_gain_word} == $past(stage3_gain_q)))
        else $error("stage one or three gain not following register");

endmodule // afs_decoder

`default_nettype wire

// ===== afs_switch_model.sv
// Model of the analog input and reference switch arrays.
// Assumes one-hot selects from the decoder, sampled as levels.
`timescale 1ns/1ps
`default_nettype none

module afs_switch_model
(
    // Input and reference switch selects.
    input  wire logic [7:0] inp_pos_sel,
    input  wire logic [7:0] inp_neg_sel,
    input  wire logic [3:0] ref_pos_sel,
    input  wire logic [3:0] ref_neg_sel,
    // Indices of the closed switches and the one-hot check.
    output logic      [2:0] pos_idx,
    output logic      [2:0] neg_idx,
    output logic      [1:0] rp_idx,
    output logic      [1:0] rn_idx,
    output logic            one_hot
);
    // Each array reports its highest closed switch; one_hot is set only when every array closes exactly one.
    always_comb
    begin
        pos_idx = 3'h0;
        neg_idx = 3'h0;
        rp_idx  = 2'h0;
        rn_idx  = 2'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (inp_pos_sel[i]) pos_idx = i[2:0];
            if (inp_neg_sel[i]) neg_idx = i[2:0];
        end
        for (int i = 0; i < 4; i++)
        begin
            if (ref_pos_sel[i]) rp_idx = i[1:0];
            if (ref_neg_sel[i]) rn_idx = i[1:0];
        end
        one_hot = $onehot(inp_pos_sel) && $onehot(inp_neg_sel) && $onehot(ref_pos_sel) && $onehot(ref_neg_sel);
    end
endmodule // afs_switch_model

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the front-end select decoder.
// Assumes a classic Wishbone slave that answers one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0, rd_dat, q;
    logic        ack, err, e, md, s1g, s2n, s3n, oh;
    logic [7:0]  ip, in;
    logic [3:0]  rp, rn, s2g;
    logic [2:0]  sen, sby, pi, ni;
    logic [1:0]  rpi, rni;
    logic [4:0]  s2t;
    logic [6:0]  s3g;
    logic [5:0]  s3m;
    logic [31:0] seed = 32'hc5b9;
    int          bad_count = 0, checks_done = 0;

    // Clock at 25 MHz.
    always #20 sys_clk = ~sys_clk;

    afs_decoder dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_dat), .wb_ack_o(ack), .wb_err_o(err),
        .inp_pos_sel(ip), .inp_neg_sel(in), .ref_pos_sel(rp), .ref_neg_sel(rn), .modulator_en(md),
        .stage_en(sen), .stage_bypass(sby), .stage1_gain_ten(s1g), .stage2_gain_oh(s2g),
        .stage2_offset_therm(s2t), .stage2_offset_neg(s2n), .stage3_gain_word(s3g),
        .stage3_offset_mag(s3m), .stage3_offset_neg(s3n));

    afs_switch_model model (.inp_pos_sel(ip), .inp_neg_sel(in), .ref_pos_sel(rp), .ref_neg_sel(rn),
        .pos_idx(pi), .neg_idx(ni), .rp_idx(rpi), .rn_idx(rni), .one_hot(oh));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Xorshift source of repeatable random values.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected positive and negative input indices for a selector code.
    function automatic logic [5:0] exp_mux(input logic [4:0] c);
        logic [2:0] p, n;
        if (!c[4])
        begin
            p = {c[1:0], 1'b1};
            n = {c[1:0], 1'b0};
        end
        else
        begin
            p = c[2:0];
            n = 3'h0;
        end
        return c[3] ? {n, p} : {p, n};
    endfunction

    // Expected stage-two gain, offset thermometer and sign.
    function automatic logic [9:0] exp_s2(input logic [5:0] c);
        logic [4:0] t;
        t = (c[2:0] <= 3'h5) ? (5'h1f >> (5 - c[2:0])) : 5'h00;
        return {4'h1 << c[5:4], t, c[3] && (t != 5'h00)};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One classic Wishbone cycle; waits for ack or err under a bound.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (ack !== 1'b1 && err !== 1'b1)
        begin
            bad_count++;
            results();
        end
        q = rd_dat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic        r;
        logic [7:0]  d;
        logic [31:0] x;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        // Reset state of registers and switches.
        wb(1'b0, 8'h00, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b0, 8'h04, 32'h0);
        `CHK(q, 32'h1)
        `CHK({md, pi, ni, rpi, rni}, {1'b1, 3'd1, 3'd0, 2'd1, 2'd0})
        // Every selector code with a random reference choice.
        for (int c = 0; c < 32; c++)
        begin
            x = rnd();
            r = x[0];
            wb(1'b1, 8'h00, {26'h0, c[4:0], r});
            `CHK({oh, pi, ni}, {1'b1, exp_mux(c[4:0])})
            `CHK({rpi, rni}, {r, 1'b1, r, 1'b0})
            wb(1'b0, 8'h00, 32'h0);
            `CHK(q, {26'h0, c[4:0], r})
        end
        // Every enable pattern.
        for (int c = 0; c < 16; c++)
        begin
            wb(1'b1, 8'h04, c);
            `CHK({md, sen, sby}, {c[0], c[3:1], ~c[3:1]})
        end
        // Every stage-two gain and offset code.
        for (int c = 0; c < 64; c++)
        begin
            wb(1'b1, 8'h08, c);
            `CHK({s2g, s2t, s2n}, exp_s2(c[5:0]))
        end
        // Stage-one gain and stage-three gain, corners then random.
        for (int k = 0; k < 10; k++)
        begin
            x = rnd();
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : x[7:0];
            wb(1'b1, 8'h0c, {24'h0, d});
            `CHK({s1g, s3g}, d)
        end
        // Every stage-three offset code.
        for (int c = 0; c < 128; c++)
        begin
            wb(1'b1, 8'h10, c);
            `CHK({s3n, s3m}, {c[6] && (c[5:0] != 6'h0), c[5:0]})
        end
        // Write without the low byte lane leaves the offset unchanged.
        @(posedge sys_clk);
        sel <= 4'he;
        wb(1'b1, 8'h10, 32'h0);
        `CHK({s3n, s3m}, 7'h7f)
        @(posedge sys_clk);
        sel <= 4'hf;
        // Unmapped address is refused with err.
        wb(1'b0, 8'h18, 32'h0);
        `CHK({e, q}, {1'b1, 32'h0})
        // Status is read-only and mirrors the last selector code 11111.
        wb(1'b1, 8'h14, 32'hffffff);
        `CHK(e, 1'b0)
        wb(1'b0, 8'h14, 32'h0);
        `CHK(q[15:0], 16'h0180)
        `CHK(q[23:16], r ? 8'h84 : 8'h21)
        // Idle: software turns the modulator off to save power.
        wb(1'b1, 8'h04, 32'h0);
        `CHK({md, sby}, {1'b0, 3'h7})
        results();
    end
endmodule // tb_top

`default_nettype wire
